/* hw/ffp_top.sv */
// friction failure predictor: register file, gating, auto thresholds, warning
// Behaviour
// R1 - The mode field decodes 0 as disabled (reset value), 1 automatic, 2 manual, 3 reset request.
// R2 - When the automatic calculation finishes, the mode field is rewritten to 2.
// R3 - A mode of 3 found at power-up clears the thresholds and turns the mode into 1.
// R4 - Upper limit equals average plus standard deviation times multiplier, in 0.1 % units.
// R5 - Lower limit equals average minus standard deviation times multiplier, in 0.1 % units.
// R6 - A multiplier of 0 is used as 5 for both limits.
// R7 - Manual prediction starts only once travel exceeds half the total travel setting.
// R8 - Automatic thresholds wait for 3 h continuous and 90 h cumulative position or velocity run; here only the cumulative count checks posvel_mode.
// R9 - No warning is raised in automatic mode before the calculation completes.
// R10 - The automatic calculation overwrites the average and deviation from the estimated friction.
// R11 - While running, the warning rises when the estimate is above upper or below lower.
// R12 - The warning falls by itself once the estimate is back between the limits.
// R13 - Prediction starts once valid upper and lower thresholds are present.
// R14 - Software should raise the multiplier to 6 or more if automatic limits warn.
// R15 - Software should load both compensation coefficients when moving to manual limits.
// R16 - An estimate equal to a limit counts as inside the range.
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ffp_top
	import ffp_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = CLK_HZ,
	parameter int unsigned CONT_SEC = CONT_RUN_SEC,
	parameter int unsigned CUM_SEC = CUM_RUN_SEC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// friction estimator and motion counters
	input wire logic [FRIC_W-1:0] fric_est,
	input wire logic fric_est_valid,
	input wire logic [31:0] travel_dist,
	input wire logic run_active,
	input wire logic posvel_mode,
	// retained mode field
	input wire logic [1:0] nv_mode,
	output logic [1:0] nv_mode_out,
	// results
	output logic friction_prediction_warning,
	output logic [3:0] pred_status
);

	localparam int unsigned TW = $clog2(TICK_CYCLES);
	localparam int unsigned SUM_W = FRIC_W + SAMPLE_LOG2;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[8*i +: 8] = wd[8*i +: 8];
		end
		return res;
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	logic wait_reg;
	logic [31:0] readdata_reg;
	logic pwr_done_reg;
	logic [1:0] prediction_mode_select_reg;
	logic [MULT_W-1:0] threshold_multiplier_reg;
	logic [31:0] total_travel_distance_setting_reg;
	logic [FRIC_W-1:0] friction_average_characteristic_reg;
	logic [FRIC_W-1:0] friction_standard_deviation_reg;
	logic [FRIC_W-1:0] compensation_coefficient_one_reg;
	logic [FRIC_W-1:0] compensation_coefficient_two_reg;
	logic thr_valid_reg;
	logic warn_reg;
	logic [3:0] status_reg;
	logic [TW-1:0] tick_cnt_reg;
	logic [SEC_W-1:0] cont_sec_reg;
	logic [SEC_W-1:0] cum_sec_reg;
	ffp_calc_state_t calc_state_reg;
	ffp_calc_state_t calc_state_next;
	logic [SAMPLE_LOG2-1:0] smp_cnt_reg;
	logic [SUM_W-1:0] sum_reg;
	logic [FRIC_W-1:0] min_reg;
	logic [FRIC_W-1:0] max_reg;

	ffp_thr_if thr ();

	ffp_thresh_calc i_ffp_thresh_calc
	(
		.clk(clk),
		.rstn(rstn),
		.thr(thr.calc)
	);

	assign thr.avg = friction_average_characteristic_reg;
	assign thr.std = friction_standard_deviation_reg;
	assign thr.mult = threshold_multiplier_reg;

	// ****************************************************************
	// bus decode: one wait state on every access
	// ****************************************************************
	wire [7:0] word_addr = {avs_address[7:2], 2'b00};
	wire acc_req = avs_read | avs_write;
	wire wr_en = avs_write & ~wait_reg;
	wire sel_mode = word_addr == OFF_MODE;
	wire sel_mult = word_addr == OFF_MULT;
	wire sel_travel = word_addr == OFF_TRAVEL;
	wire sel_avg = word_addr == OFF_AVG;
	wire sel_std = word_addr == OFF_STD;
	wire sel_coef1 = word_addr == OFF_COEF1;
	wire sel_coef2 = word_addr == OFF_COEF2;
	wire sel_status = word_addr == OFF_STATUS;
	wire sel_upper = word_addr == OFF_UPPER;
	wire sel_lower = word_addr == OFF_LOWER;
	wire [31:0] rd_mux =
		sel_mode ? {30'h0, prediction_mode_select_reg} :
		sel_mult ? {28'h0, threshold_multiplier_reg} :
		sel_travel ? total_travel_distance_setting_reg :
		sel_avg ? {16'h0, friction_average_characteristic_reg} :
		sel_std ? {16'h0, friction_standard_deviation_reg} :
		sel_coef1 ? {16'h0, compensation_coefficient_one_reg} :
		sel_coef2 ? {16'h0, compensation_coefficient_two_reg} :
		sel_status ? {27'h0, warn_reg, status_reg} :
		sel_upper ? {8'h0, thr.upper} :
		sel_lower ? {8'h0, thr.lower} : 32'h0000_0000;
	wire [31:0] wr_merged = be_merge(rd_mux, avs_writedata, avs_byteenable);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end
		else
		begin
			wait_reg <= ~(acc_req & wait_reg);
			if (avs_read && wait_reg)
				readdata_reg <= rd_mux;
		end
	end

	// ****************************************************************
	// power-up mode capture and gating
	// ****************************************************************
	wire pwr_first = ~pwr_done_reg;
	wire pwr_reset_req = pwr_first && nv_mode == MODE_RESET;
	wire calc_write = calc_state_reg == CS_WRITE;
	wire travel_half = {travel_dist, 1'b0} > {1'b0, total_travel_distance_setting_reg}; // R7
	wire tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);
	wire cont_ok = cont_sec_reg >= SEC_W'(CONT_SEC);
	wire cum_ok = cum_sec_reg >= SEC_W'(CUM_SEC);
	wire auto_mode = prediction_mode_select_reg == MODE_AUTO;
	wire count_en = auto_mode && travel_half;
	// power-up and calculation results take priority over a colliding bus write
	wire [1:0] mode_next =
		pwr_reset_req ? MODE_AUTO : // R3
		pwr_first ? nv_mode :
		calc_write ? MODE_MANUAL : // R2
		(wr_en && sel_mode) ? wr_merged[1:0] : prediction_mode_select_reg;
	wire avg_sw_wr = wr_en && sel_avg;
	wire std_sw_wr = wr_en && sel_std;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pwr_done_reg <= 1'b0;
			prediction_mode_select_reg <= MODE_RST; // R1
		end
		else
		begin
			pwr_done_reg <= 1'b1;
			prediction_mode_select_reg <= mode_next;
		end
	end

	// ****************************************************************
	// parameter registers
	// ****************************************************************
	wire [SUM_W-1:0] avg_full = $signed(sum_reg) >>> SAMPLE_LOG2;
	wire [FRIC_W-1:0] calc_avg = avg_full[FRIC_W-1:0];
	wire [FRIC_W-1:0] calc_range = max_reg - min_reg;
	wire [FRIC_W-1:0] calc_std = {1'b0, calc_range[FRIC_W-1:1]};

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			threshold_multiplier_reg <= MULT_RST;
			total_travel_distance_setting_reg <= TRAVEL_RST;
			friction_average_characteristic_reg <= AVG_RST;
			friction_standard_deviation_reg <= STD_RST;
			compensation_coefficient_one_reg <= COEF_RST;
			compensation_coefficient_two_reg <= COEF_RST;
			thr_valid_reg <= 1'b0;
		end
		else
		begin
			if (wr_en && sel_mult)
				threshold_multiplier_reg <= wr_merged[MULT_W-1:0];
			if (wr_en && sel_travel)
				total_travel_distance_setting_reg <= wr_merged;
			if (wr_en && sel_coef1)
				compensation_coefficient_one_reg <= wr_merged[FRIC_W-1:0];
			if (wr_en && sel_coef2)
				compensation_coefficient_two_reg <= wr_merged[FRIC_W-1:0];
			if (pwr_reset_req)
			begin
				friction_average_characteristic_reg <= AVG_RST; // R3
				friction_standard_deviation_reg <= STD_RST;
				thr_valid_reg <= 1'b0;
			end
			else if (calc_write)
			begin
				friction_average_characteristic_reg <= calc_avg; // R10
				friction_standard_deviation_reg <= calc_std;
				thr_valid_reg <= 1'b1;
			end
			else
			begin
				if (avg_sw_wr)
					friction_average_characteristic_reg <= wr_merged[FRIC_W-1:0];
				if (std_sw_wr)
					friction_standard_deviation_reg <= wr_merged[FRIC_W-1:0];
				if (avg_sw_wr || std_sw_wr)
					thr_valid_reg <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// run-time counters: one tick per second
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_cnt_reg <= '0;
			cont_sec_reg <= '0;
			cum_sec_reg <= '0;
		end
		else
		begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
			// any stop breaks the continuous run
			if (!count_en || !run_active)
				cont_sec_reg <= '0;
			else if (tick && !cont_ok)
				cont_sec_reg <= cont_sec_reg + SEC_W'(1); // R8
			if (count_en && run_active && posvel_mode && tick && !cum_ok)
				cum_sec_reg <= cum_sec_reg + SEC_W'(1); // R8
		end
	end

	// ****************************************************************
	// automatic threshold calculation
	// ****************************************************************
	wire last_smp = smp_cnt_reg == '1;

	always_comb
	begin
		calc_state_next = calc_state_reg;
		unique case (calc_state_reg)
			CS_WAIT:
				if (count_en && cont_ok && cum_ok) // R8
					calc_state_next = CS_COLLECT;
			CS_COLLECT:
				if (!auto_mode)
					calc_state_next = CS_WAIT;
				else if (fric_est_valid && last_smp)
					calc_state_next = CS_WRITE;
			CS_WRITE:
				calc_state_next = CS_WAIT;
			default:
				calc_state_next = CS_WAIT;
		endcase
	end

	wire first_smp = smp_cnt_reg == '0;
	wire smp_lo = first_smp || $signed(fric_est) < $signed(min_reg);
	wire smp_hi = first_smp || $signed(fric_est) > $signed(max_reg);
	wire [SUM_W-1:0] est_sum_ext = {{SAMPLE_LOG2{fric_est[FRIC_W-1]}}, fric_est};

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			calc_state_reg <= CS_WAIT;
			smp_cnt_reg <= '0;
			sum_reg <= '0;
			min_reg <= '0;
			max_reg <= '0;
		end
		else
		begin
			calc_state_reg <= calc_state_next;
			if (calc_state_reg != CS_COLLECT)
			begin
				smp_cnt_reg <= '0;
				sum_reg <= '0;
			end
			else if (fric_est_valid)
			begin
				smp_cnt_reg <= smp_cnt_reg + SAMPLE_LOG2'(1);
				sum_reg <= sum_reg + est_sum_ext;
				if (smp_lo)
					min_reg <= fric_est;
				if (smp_hi)
					max_reg <= fric_est;
			end
		end
	end

	// ****************************************************************
	// warning and status
	// ****************************************************************
	wire [THR_W-1:0] est_ext = {{(THR_W-FRIC_W){fric_est[FRIC_W-1]}}, fric_est};
	// equal to a limit is inside
	wire above = $signed(est_ext) > $signed(thr.upper); // R16
	wire below = $signed(est_ext) < $signed(thr.lower); // R16
	// auto mode never runs: running needs manual mode, which the calculation sets as it writes thresholds
	wire running = prediction_mode_select_reg == MODE_MANUAL && travel_half && thr_valid_reg; // R9 R13
	wire warn_next = !running ? 1'b0 : fric_est_valid ? (above | below) : warn_reg; // R11 R12
	wire [3:0] status_next =
		(prediction_mode_select_reg == MODE_OFF || prediction_mode_select_reg == MODE_RESET)
		? STAT_OFF : warn_next ? STAT_WARN : running ? STAT_RUN : STAT_PREP;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			warn_reg <= 1'b0;
			status_reg <= STAT_OFF;
		end
		else
		begin
			warn_reg <= warn_next;
			status_reg <= status_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = readdata_reg;
	assign nv_mode_out = prediction_mode_select_reg;
	assign friction_prediction_warning = warn_reg;
	assign pred_status = status_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_off_quiet;
		prediction_mode_select_reg == MODE_OFF |=> !warn_reg && status_reg == STAT_OFF;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled mode shows activity"); // R1

	property p_auto_rewrite;
		calc_state_reg == CS_WRITE && !pwr_first
		|=> prediction_mode_select_reg == MODE_MANUAL && thr_valid_reg;
	endproperty
	a_auto_rewrite: assert property (p_auto_rewrite) else $error("mode not rewritten to 2"); // R2

	property p_pwr_reset;
		pwr_first && nv_mode == MODE_RESET
		|=> prediction_mode_select_reg == MODE_AUTO && !thr_valid_reg
		&& friction_average_characteristic_reg == AVG_RST;
	endproperty
	a_pwr_reset: assert property (p_pwr_reset) else $error("power-up reset request not honoured"); // R3

	property p_travel_gate;
		$rose(warn_reg) |-> $past(travel_half);
	endproperty
	a_travel_gate: assert property (p_travel_gate) else $error("warning before half travel"); // R7

	property p_auto_gate;
		$rose(calc_state_reg == CS_COLLECT)
		|-> cum_sec_reg >= SEC_W'(CUM_SEC) && $past(cont_sec_reg) >= SEC_W'(CONT_SEC);
	endproperty
	a_auto_gate: assert property (p_auto_gate) else $error("calculation started too early"); // R8

	property p_auto_silent;
		auto_mode ##1 auto_mode |-> !warn_reg;
	endproperty
	a_auto_silent: assert property (p_auto_silent) else $error("warning in automatic mode"); // R9

	property p_warn_set;
		running && fric_est_valid && (above || below) |=> warn_reg && status_reg == STAT_WARN;
	endproperty
	a_warn_set: assert property (p_warn_set) else $error("excursion did not raise warning"); // R11

	property p_warn_clear;
		warn_reg && fric_est_valid && !above && !below |=> !warn_reg;
	endproperty
	a_warn_clear: assert property (p_warn_clear) else $error("warning not cleared in range"); // R12

	property p_valid_needed;
		$rose(warn_reg) |-> $past(thr_valid_reg);
	endproperty
	a_valid_needed: assert property (p_valid_needed) else $error("warning without thresholds"); // R13

	property p_equal_inside;
		running && fric_est_valid && (est_ext == thr.upper || est_ext == thr.lower)
		&& $signed(thr.lower) <= $signed(thr.upper) |=> !warn_reg;
	endproperty
	a_equal_inside: assert property (p_equal_inside) else $error("limit value treated as outside"); // R16

endmodule
`default_nettype wire

/* hw/ffp_pkg.sv */
// friction failure predictor: shared constants, register map and types
package ffp_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned SEC_PER_HOUR = 3600;
	localparam int unsigned CONT_RUN_HOURS = 3;
	localparam int unsigned CUM_RUN_HOURS = 90;
	localparam int unsigned CONT_RUN_SEC = CONT_RUN_HOURS * SEC_PER_HOUR;
	localparam int unsigned CUM_RUN_SEC = CUM_RUN_HOURS * SEC_PER_HOUR;
	localparam int unsigned SAMPLE_LOG2 = 4;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int unsigned FRIC_W = 16;
	localparam int unsigned MULT_W = 4;
	localparam int unsigned PROD_W = FRIC_W + MULT_W;
	localparam int unsigned THR_W = 24;
	localparam int unsigned SEC_W = 32;

	// ****************************************************************
	// mode field encoding
	// ****************************************************************
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_AUTO = 2'h1;
	localparam logic [1:0] MODE_MANUAL = 2'h2;
	localparam logic [1:0] MODE_RESET = 2'h3;
	localparam logic [MULT_W-1:0] MULT_DEFAULT = 4'h5;

	// ****************************************************************
	// prediction status codes
	// ****************************************************************
	localparam logic [3:0] STAT_OFF = 4'h0;
	localparam logic [3:0] STAT_PREP = 4'h1;
	localparam logic [3:0] STAT_RUN = 4'h2;
	localparam logic [3:0] STAT_WARN = 4'h3;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_MULT = 8'h04;
	localparam logic [7:0] OFF_TRAVEL = 8'h08;
	localparam logic [7:0] OFF_AVG = 8'h0c;
	localparam logic [7:0] OFF_STD = 8'h10;
	localparam logic [7:0] OFF_COEF1 = 8'h14;
	localparam logic [7:0] OFF_COEF2 = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_UPPER = 8'h20;
	localparam logic [7:0] OFF_LOWER = 8'h24;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [MULT_W-1:0] MULT_RST = 4'h0;
	localparam logic [31:0] TRAVEL_RST = 32'h0000_0000;
	localparam logic [FRIC_W-1:0] AVG_RST = 16'h0000;
	localparam logic [FRIC_W-1:0] STD_RST = 16'h0000;
	localparam logic [FRIC_W-1:0] COEF_RST = 16'h0000;

	// ****************************************************************
	// automatic threshold calculation states
	// ****************************************************************
	typedef enum logic [2:0] {
		CS_WAIT = 3'b001,
		CS_COLLECT = 3'b010,
		CS_WRITE = 3'b100
	} ffp_calc_state_t;

endpackage

/* hw/ffp_thr_if.sv */
// friction failure predictor: threshold parameters and limits between modules
`timescale 1ns/10ps
`default_nettype none
interface ffp_thr_if;
	import ffp_pkg::*;
	logic [FRIC_W-1:0] avg;
	logic [FRIC_W-1:0] std;
	logic [MULT_W-1:0] mult;
	logic [THR_W-1:0] upper;
	logic [THR_W-1:0] lower;

	modport calc
	(
		input avg,
		input std,
		input mult,
		output upper,
		output lower
	);

	modport user
	(
		output avg,
		output std,
		output mult,
		input upper,
		input lower
	);
endinterface
`default_nettype wire

/* hw/ffp_thresh_calc.sv */
// friction failure predictor: upper and lower limit threshold arithmetic
`timescale 1ns/10ps
`default_nettype none
module ffp_thresh_calc
	import ffp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// parameters in, limits out
	ffp_thr_if.calc thr
);

	wire [MULT_W-1:0] mult_eff;
	wire [PROD_W-1:0] spread;
	wire [THR_W-1:0] avg_ext;
	wire [THR_W-1:0] spread_ext;
	logic [THR_W-1:0] upper_reg;
	logic [THR_W-1:0] lower_reg;

	assign mult_eff = (thr.mult == '0) ? MULT_DEFAULT : thr.mult; // R6
	assign spread = PROD_W'(thr.std) * PROD_W'(mult_eff);
	assign avg_ext = {{(THR_W-FRIC_W){thr.avg[FRIC_W-1]}}, thr.avg};
	assign spread_ext = {{(THR_W-PROD_W){1'b0}}, spread};

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			upper_reg <= '0;
			lower_reg <= '0;
		end
		else
		begin
			upper_reg <= avg_ext + spread_ext; // R4
			lower_reg <= avg_ext - spread_ext; // R5
		end
	end

	assign thr.upper = upper_reg;
	assign thr.lower = lower_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_upper_sum;
		$stable(thr.avg) && $stable(thr.std) && $stable(thr.mult) && thr.mult != '0
		|=> (upper_reg - $past(avg_ext)) == THR_W'($past(thr.std) * $past(thr.mult));
	endproperty
	a_upper_sum: assert property (p_upper_sum) else $error("upper limit not avg plus spread"); // R4

	property p_lower_sym;
		##1 $stable(thr.avg) |-> (upper_reg + lower_reg) == THR_W'(avg_ext + avg_ext);
	endproperty
	a_lower_sym: assert property (p_lower_sym) else $error("lower limit not avg minus spread"); // R5

	property p_mult_default;
		thr.mult == '0 ##1 $stable(thr.std) && $stable(thr.avg)
		|-> (upper_reg - lower_reg) == THR_W'(thr.std) * THR_W'(10);
	endproperty
	a_mult_default: assert property (p_mult_default) else $error("zero multiplier not taken as 5"); // R6

endmodule
`default_nettype wire

/* sim/friction_failure_predictor_test.sv */
// friction failure predictor: self-checking bus-level testbench
`timescale 1ns/10ps
`default_nettype none
module friction_failure_predictor_test;
	import ffp_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wait_req;
	logic [FRIC_W-1:0] est = 16'h0;
	logic est_vld = 1'b0;
	logic [31:0] trav = 32'h0;
	logic run = 1'b0;
	logic posvel = 1'b0;
	logic [1:0] nv = 2'h0;
	logic [1:0] nv_out;
	logic warn;
	logic [3:0] stat;
	logic [31:0] rv;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;

	always #2 clk = ~clk;

	// short second tick keeps the run-time gates within a few hundred cycles
	ffp_top #(.TICK_CYCLES(4), .CONT_SEC(3), .CUM_SEC(30)) i_ffp_top
	(
		.clk(clk),
		.rstn(rstn),
		.avs_address(addr),
		.avs_read(rd),
		.avs_write(wr),
		.avs_writedata(wdata),
		.avs_byteenable(4'hf),
		.avs_readdata(rdata),
		.avs_waitrequest(wait_req),
		.fric_est(est),
		.fric_est_valid(est_vld),
		.travel_dist(trav),
		.run_active(run),
		.posvel_mode(posvel),
		.nv_mode(nv),
		.nv_mode_out(nv_out),
		.friction_prediction_warning(warn),
		.pred_status(stat)
	);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one access: held until waitrequest is seen low at a rising edge
	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= is_wr;
		rd <= !is_wr;
		do @(posedge clk); while (wait_req !== 1'b0);
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		chk(what, rv, exp);
	endtask

	// one estimate pulse, then the warning is looked at once it has settled
	task automatic feed(input logic [15:0] v, input logic exp_warn);
		@(posedge clk);
		est <= v;
		est_vld <= 1'b1;
		@(posedge clk);
		est_vld <= 1'b0;
		@(posedge clk);
		chk("warning", {31'h0, warn}, {31'h0, exp_warn});
	endtask

	task automatic do_reset(input logic [1:0] m);
		@(posedge clk);
		rstn <= 1'b0;
		nv <= m;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	initial
	begin
		do_reset(MODE_OFF);
		rchk(OFF_MODE, 32'h0, "mode");
		chk("status", {28'h0, stat}, {28'h0, STAT_OFF});
		// ****************************************************************
		// manual thresholds and gating on travel
		// ****************************************************************
		bus(1'b1, OFF_TRAVEL, 32'h0000_03e8);
		@(posedge clk);
		trav <= 32'h0000_01f4;
		bus(1'b1, OFF_MODE, {30'h0, MODE_MANUAL});
		bus(1'b1, OFF_AVG, 32'h0000_0064);
		bus(1'b1, OFF_STD, 32'h0000_000a);
		rchk(OFF_UPPER, 32'h0000_0096, "upper x0");
		rchk(OFF_LOWER, 32'h0000_0032, "lower x0");
		chk("status", {28'h0, stat}, {28'h0, STAT_PREP});
		@(posedge clk);
		trav <= 32'h0000_01f5;
		repeat (2) @(posedge clk);
		chk("status", {28'h0, stat}, {28'h0, STAT_RUN});
		bus(1'b1, OFF_MULT, 32'h0000_0003);
		rchk(OFF_UPPER, 32'h0000_0082, "upper x3");
		rchk(OFF_LOWER, 32'h0000_0046, "lower x3");
		feed(16'h0083, 1'b1);
		chk("status", {28'h0, stat}, {28'h0, STAT_WARN});
		feed(16'h0082, 1'b0);
		feed(16'h0045, 1'b1);
		feed(16'h0046, 1'b0);
		bus(1'b1, OFF_UPPER, 32'h0000_0fff);
		rchk(OFF_UPPER, 32'h0000_0082, "upper ro");
		rchk(OFF_STATUS, 32'h0000_0002, "status reg");
		rchk(8'h40, 32'h0, "unmapped");
		// ****************************************************************
		// automatic thresholds
		// ****************************************************************
		bus(1'b1, OFF_MODE, {30'h0, MODE_AUTO});
		@(posedge clk);
		run <= 1'b1;
		posvel <= 1'b1;
		// more than a full sample set arrives before the cumulative gate opens
		repeat (20) feed(16'h03e7, 1'b0);
		rchk(OFF_MODE, {30'h0, MODE_AUTO}, "mode before gates");
		repeat (80) @(posedge clk);
		for (int i = 0; i < 20; i++)
			feed(i[0] ? 16'h00d2 : 16'h00be, 1'b0);
		rchk(OFF_MODE, {30'h0, MODE_MANUAL}, "mode after calc");
		chk("nv mode out", {30'h0, nv_out}, {30'h0, MODE_MANUAL});
		rchk(OFF_AVG, 32'h0000_00c8, "auto avg");
		rchk(OFF_STD, 32'h0000_000a, "auto std");
		rchk(OFF_UPPER, 32'h0000_00e6, "auto upper");
		rchk(OFF_LOWER, 32'h0000_00aa, "auto lower");
		feed(16'h00e7, 1'b1);
		feed(16'h00aa, 1'b0);
		bus(1'b1, OFF_MULT, 32'h0000_0006);
		rchk(OFF_UPPER, 32'h0000_0104, "upper x6");
		rchk(OFF_LOWER, 32'h0000_008c, "lower x6");
		feed(16'h0105, 1'b1);
		feed(16'h00e7, 1'b0);
		bus(1'b1, OFF_COEF1, 32'h0000_00c8);
		bus(1'b1, OFF_COEF2, 32'h0000_000a);
		rchk(OFF_COEF1, 32'h0000_00c8, "coef1");
		rchk(OFF_COEF2, 32'h0000_000a, "coef2");
		// ****************************************************************
		// retained mode across a power cycle
		// ****************************************************************
		bus(1'b1, OFF_MODE, {30'h0, MODE_RESET});
		rchk(OFF_STATUS, 32'h0, "status mode 3");
		chk("nv mode out", {30'h0, nv_out}, {30'h0, MODE_RESET});
		do_reset(MODE_RESET);
		rchk(OFF_MODE, {30'h0, MODE_AUTO}, "mode after reset req");
		chk("nv mode out", {30'h0, nv_out}, {30'h0, MODE_AUTO});
		do_reset(MODE_MANUAL);
		rchk(OFF_MODE, {30'h0, MODE_MANUAL}, "mode retained");
		give_verdict();
	end
endmodule
`default_nettype wire
